// [design/nfbi_pkg.sv]
// Package with constants and types for the NAND flash bus controller.
package nfbi_pkg;
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned STROBE_LOW_NS = 100;
   localparam logic [3:0] STROBE_LOW_CYC =
      4'((STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int unsigned STROBE_HIGH_NS = 100;
   localparam logic [3:0] STROBE_HIGH_CYC =
      4'((STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] DIV_RESET = 4'h0;
   localparam logic [2:0] ADDR_CYCLES_FULL = 3'h5;
   localparam logic [2:0] ADDR_CYCLES_ROW = 3'h3;
   localparam logic [2:0] ADDR_FIRST_FULL = 3'h0;
   localparam logic [2:0] ADDR_FIRST_ROW = 3'h2;
   localparam logic [7:0] CMD_RESET = 8'hff;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam int unsigned COL_LO_POS = 0;
   localparam int unsigned COL_HI_POS = 8;
   localparam int unsigned ROW_A_POS = 11;
   localparam int unsigned ROW_B_POS = 19;
   localparam int unsigned ROW_C_POS = 27;
   localparam logic [15:0] IO_RESET = 16'h0000;
   localparam logic [28:0] ADDR_RESET = 29'h0;

   typedef enum logic [1:0] {
      NFBI_OP_CMD = 2'h0,
      NFBI_OP_ADDR = 2'h1,
      NFBI_OP_WDATA = 2'h2,
      NFBI_OP_RDATA = 2'h3
   } nfbi_op_type;

   typedef enum logic [2:0] {
      NFBI_IDLE = 3'b000,
      NFBI_SETUP = 3'b001,
      NFBI_LOW = 3'b011,
      NFBI_HIGH = 3'b010,
      NFBI_DONE = 3'b110
   } nfbi_state_type;
endpackage

// [design/nfbi_buf2.sv]
// Two-entry buffer for read data heading to the user.
`timescale 1ns/1ps
module nfbi_buf2 (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [15:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [15:0] out_data_o
);
   logic [15:0] mem_r [2];
   logic [15:0] mem_nxt [2];
   logic [1:0] cnt_r, cnt_nxt;
   logic wp_r, wp_nxt, rp_r, rp_nxt;
   logic push, pop;

   assign push = in_valid_i && (cnt_r != 2'h2);
   assign pop = out_valid_o && out_ready_i;
   assign in_ready_o = (cnt_r != 2'h2);
   assign out_valid_o = (cnt_r != 2'h0);
   assign out_data_o = mem_r[rp_r];

   always_comb begin
      mem_nxt = mem_r;
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      cnt_nxt = cnt_r;
      if (push) begin
         mem_nxt[wp_r] = in_data_i;
         wp_nxt = ~wp_r;
      end
      if (pop) begin
         rp_nxt = ~rp_r;
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 2'h1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 2'h1;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mem_r[0] <= 16'h0000;
         mem_r[1] <= 16'h0000;
         cnt_r <= 2'h0;
         wp_r <= 1'b0;
         rp_r <= 1'b0;
      end else begin
         mem_r <= mem_nxt;
         cnt_r <= cnt_nxt;
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end
endmodule

// [design/nfbi_ctrl.sv]
// Controller that drives a sixteen-bit NAND flash over its strobed bus.
// Functional notes
// RULE1: Command latch high: write strobe rising edge captures the command byte.
// RULE2: Address latch high: write strobe rising edge captures an address byte.
// RULE3: Both latches low: write strobe rising edge captures a data word.
// RULE4: Flash floats its I/O lines when deselected or outputs disabled.
// RULE5: Commands and addresses use low eight lines; upper eight carry data only.
// RULE6: Busy flash ignores select going high during program or erase.
// RULE7: Read strobe falling edge presents next word and bumps column counter.
// RULE8: Write protect low holds the high-voltage generator in reset.
// RULE9: Ready/busy low during program, erase or array read; high when done.
// RULE10: Ready/busy is open drain and reports even when deselected.
// RULE11: Power-on read enable high makes flash auto-read at power-on.
// RULE12: Column sent in two cycles: A0-A7, then A8-A10.
// RULE13: Row sent in three cycles: A11-A18, A19-A26, then A27-A28.
// RULE14: Controller drives every non-address line low during address cycles.
// RULE15: Flash ignores address cycles beyond what the operation needs.
// RULE16: Controller holds select low and pulses write strobe low per write.
// RULE17: Read and program take five address cycles; erase takes three row cycles.
// RULE18: Read, program, erase use setup plus confirm commands; reset, status single.
// RULE19: While busy, only reset and status-read commands may be issued.
// RULE20: Command latch and address latch are never high together.
`timescale 1ns/1ps
module nfbi_ctrl (
   input wire logic clk_i,
   input wire logic arst_n_i,
   // User request: one bus cycle of the kind given by op_i; an address request runs all of its address cycles.
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire nfbi_pkg::nfbi_op_type op_i,
   input wire logic [7:0] cmd_i,
   input wire logic [28:0] addr_i,
   input wire logic addr_row_only_i,
   input wire logic [15:0] wdata_i,
   input wire logic write_protect_req_i,
   output logic [15:0] rdata_o,
   output logic rdata_valid_o,
   input wire logic rdata_ready_i,
   output logic flash_ready_o,
   output logic cmd_refused_o,
   // Flash pins.
   output logic chip_select_first_n_o,
   output logic cmd_latch_o,
   output logic addr_latch_o,
   output logic write_strobe_n_o,
   output logic read_strobe_n_o,
   output logic write_protect_n_o,
   output logic [15:0] io_bus_o,
   output logic io_bus_oe_n_o,
   input wire logic [15:0] io_bus_i,
   input wire logic ready_busy_n_i
);
   import nfbi_pkg::*;

   nfbi_state_type st_r, st_nxt;
   nfbi_op_type op_r, op_nxt;
   logic [3:0] div_r, div_nxt;
   logic [2:0] acyc_r, acyc_nxt;
   logic [2:0] alast_r, alast_nxt;
   logic [28:0] addr_r, addr_nxt;
   logic [15:0] wdata_r, wdata_nxt;
   logic [7:0] cmd_r, cmd_nxt;
   logic ce_n_r, ce_n_nxt, cle_r, cle_nxt, ale_r, ale_nxt;
   logic we_n_r, we_n_nxt, re_n_r, re_n_nxt, wp_n_r, wp_n_nxt;
   logic [15:0] io_r, io_nxt;
   logic oe_n_r, oe_n_nxt;
   logic rdy_r, rdy_nxt, refused_r, refused_nxt, ack_r, ack_nxt;
   logic push_r, push_nxt;
   logic [15:0] cap_r, cap_nxt;
   logic buf_ready, buf_valid;
   logic [15:0] buf_data;
   logic tick;
   logic cmd_ok;
   logic [7:0] addr_byte;
   logic [15:0] rdata_r, rdata_nxt;
   logic rvalid_r, rvalid_nxt;
   logic take, out_room;

   assign tick = (div_r == 4'h0);
   // Only reset and status-read are legal while the flash reports busy.
   assign cmd_ok = ready_busy_n_i || (cmd_i == CMD_RESET) || (cmd_i == CMD_STATUS); // see RULE19

   // Address byte for the current cycle, upper bits of the A8-A10 and A27-A28 bytes forced low.
   always_comb begin
      case (acyc_r)
         3'h0: addr_byte = addr_r[COL_LO_POS +: 8]; // see RULE12
         3'h1: addr_byte = {5'h00, addr_r[COL_HI_POS +: 3]}; // see RULE12, RULE14
         3'h2: addr_byte = addr_r[ROW_A_POS +: 8]; // see RULE13
         3'h3: addr_byte = addr_r[ROW_B_POS +: 8]; // see RULE13
         3'h4: addr_byte = {6'h00, addr_r[ROW_C_POS +: 2]}; // see RULE13, RULE14
         default: addr_byte = 8'h00;
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      op_nxt = op_r;
      div_nxt = tick ? 4'h0 : div_r - 4'h1;
      acyc_nxt = acyc_r;
      alast_nxt = alast_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      cmd_nxt = cmd_r;
      ce_n_nxt = ce_n_r;
      cle_nxt = cle_r;
      ale_nxt = ale_r;
      we_n_nxt = we_n_r;
      re_n_nxt = re_n_r;
      wp_n_nxt = ~write_protect_req_i; // see RULE8
      io_nxt = io_r;
      oe_n_nxt = oe_n_r;
      rdy_nxt = ready_busy_n_i; // see RULE9, RULE10
      refused_nxt = 1'b0;
      ack_nxt = 1'b0;
      push_nxt = 1'b0;
      cap_nxt = cap_r;
      case (st_r)
         NFBI_IDLE: begin
            cle_nxt = 1'b0;
            ale_nxt = 1'b0;
            oe_n_nxt = 1'b1;
            if (req_valid_i && !ack_r) begin
               ack_nxt = 1'b1;
               if (op_i == NFBI_OP_CMD && !cmd_ok) begin
                  refused_nxt = 1'b1;
               end else if (op_i == NFBI_OP_RDATA && !buf_ready) begin
                  // Back-pressure: hold the read until the buffer has room.
                  ack_nxt = 1'b0;
               end else begin
                  op_nxt = op_i;
                  cmd_nxt = cmd_i;
                  addr_nxt = addr_i;
                  wdata_nxt = wdata_i;
                  acyc_nxt = addr_row_only_i ? ADDR_FIRST_ROW : ADDR_FIRST_FULL; // see RULE17
                  alast_nxt = 3'h4;
                  ce_n_nxt = 1'b0; // see RULE16
                  st_nxt = NFBI_SETUP;
                  div_nxt = STROBE_HIGH_CYC - 4'h1;
               end
            end
         end
         NFBI_SETUP: begin
            if (tick) begin
               // Latch inputs are mutually exclusive by construction.
               cle_nxt = (op_r == NFBI_OP_CMD); // see RULE1, RULE20
               ale_nxt = (op_r == NFBI_OP_ADDR); // see RULE2, RULE20
               oe_n_nxt = (op_r == NFBI_OP_RDATA);
               case (op_r)
                  NFBI_OP_CMD: io_nxt = {8'h00, cmd_r}; // see RULE5, RULE18
                  NFBI_OP_ADDR: io_nxt = {8'h00, addr_byte}; // see RULE5, RULE14
                  NFBI_OP_WDATA: io_nxt = wdata_r; // see RULE3
                  default: io_nxt = IO_RESET;
               endcase
               if (op_r == NFBI_OP_RDATA) begin
                  re_n_nxt = 1'b0; // see RULE7
               end else begin
                  we_n_nxt = 1'b0; // see RULE16
               end
               st_nxt = NFBI_LOW;
               div_nxt = STROBE_LOW_CYC - 4'h1;
            end
         end
         NFBI_LOW: begin
            if (tick) begin
               // Sample read data just before the read strobe rises.
               if (op_r == NFBI_OP_RDATA) begin
                  cap_nxt = io_bus_i; // see RULE7
                  push_nxt = 1'b1;
               end
               we_n_nxt = 1'b1;
               re_n_nxt = 1'b1;
               st_nxt = NFBI_HIGH;
               div_nxt = STROBE_HIGH_CYC - 4'h1;
            end
         end
         NFBI_HIGH: begin
            if (tick) begin
               if (op_r == NFBI_OP_ADDR && acyc_r != alast_r) begin
                  acyc_nxt = acyc_r + 3'h1;
                  st_nxt = NFBI_SETUP;
                  div_nxt = 4'h0;
               end else begin
                  st_nxt = NFBI_DONE;
               end
            end
         end
         NFBI_DONE: begin
            cle_nxt = 1'b0;
            ale_nxt = 1'b0;
            oe_n_nxt = 1'b1;
            io_nxt = IO_RESET;
            st_nxt = NFBI_IDLE;
         end
         default: st_nxt = NFBI_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_r <= NFBI_IDLE;
         op_r <= NFBI_OP_CMD;
         div_r <= DIV_RESET;
         acyc_r <= 3'h0;
         alast_r <= 3'h4;
         addr_r <= ADDR_RESET;
         wdata_r <= IO_RESET;
         cmd_r <= 8'h00;
         ce_n_r <= 1'b1;
         cle_r <= 1'b0;
         ale_r <= 1'b0;
         we_n_r <= 1'b1;
         re_n_r <= 1'b1;
         wp_n_r <= 1'b0;
         io_r <= IO_RESET;
         oe_n_r <= 1'b1;
         rdy_r <= 1'b0;
         refused_r <= 1'b0;
         ack_r <= 1'b0;
         push_r <= 1'b0;
         cap_r <= IO_RESET;
      end else begin
         st_r <= st_nxt;
         op_r <= op_nxt;
         div_r <= div_nxt;
         acyc_r <= acyc_nxt;
         alast_r <= alast_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         cmd_r <= cmd_nxt;
         ce_n_r <= ce_n_nxt;
         cle_r <= cle_nxt;
         ale_r <= ale_nxt;
         we_n_r <= we_n_nxt;
         re_n_r <= re_n_nxt;
         wp_n_r <= wp_n_nxt;
         io_r <= io_nxt;
         oe_n_r <= oe_n_nxt;
         rdy_r <= rdy_nxt;
         refused_r <= refused_nxt;
         ack_r <= ack_nxt;
         push_r <= push_nxt;
         cap_r <= cap_nxt;
      end
   end

   // A read is only launched when the buffer has room, so a push never drops.
   nfbi_buf2 u_buf (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .in_valid_i(push_r),
      .in_ready_o(buf_ready),
      .in_data_i(cap_r),
      .out_valid_o(buf_valid),
      .out_ready_i(out_room),
      .out_data_o(buf_data)
   );

   // The buffer lets go of a word only when the output register takes it, else it repeats.
   assign out_room = !rvalid_r || rdata_ready_i;
   assign take = buf_valid && out_room;

   always_comb begin
      rdata_nxt = take ? buf_data : rdata_r;
      rvalid_nxt = take || (rvalid_r && !rdata_ready_i);
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_r <= IO_RESET;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   assign req_ready_o = ack_r;
   assign rdata_o = rdata_r;
   assign rdata_valid_o = rvalid_r;
   assign flash_ready_o = rdy_r;
   assign cmd_refused_o = refused_r;
   assign chip_select_first_n_o = ce_n_r;
   assign cmd_latch_o = cle_r;
   assign addr_latch_o = ale_r;
   assign write_strobe_n_o = we_n_r;
   assign read_strobe_n_o = re_n_r;
   assign write_protect_n_o = wp_n_r;
   assign io_bus_o = io_r;
   assign io_bus_oe_n_o = oe_n_r;
endmodule

// [sim/nfbi_ctrl_monitor.sv]
// Assertion checker on the flash pins of the bus controller.
`timescale 1ns/1ps
module nfbi_ctrl_monitor (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic req_ready_o,
   input wire logic cmd_refused_o,
   input wire logic write_protect_req_i,
   input wire logic chip_select_first_n_o,
   input wire logic cmd_latch_o,
   input wire logic addr_latch_o,
   input wire logic write_strobe_n_o,
   input wire logic read_strobe_n_o,
   input wire logic write_protect_n_o,
   input wire logic [15:0] io_bus_o,
   input wire logic io_bus_oe_n_o,
   input wire logic ready_busy_n_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   latch_excl_a: assert property (!(cmd_latch_o && addr_latch_o)) else $error("latches");
   cmd_lanes_a: assert property (cmd_latch_o && !write_strobe_n_o |->
      io_bus_o[15:8] == 8'h00 && !io_bus_oe_n_o) else $error("cmd lanes");
   addr_lanes_a: assert property (addr_latch_o && !write_strobe_n_o |->
      io_bus_o[15:8] == 8'h00) else $error("addr lanes");
   write_select_a: assert property (!write_strobe_n_o |-> !chip_select_first_n_o)
      else $error("write unselected");
   write_pulse_a: assert property ($fell(write_strobe_n_o) |=> write_strobe_n_o)
      else $error("write pulse");
   refuse_ack_a: assert property (cmd_refused_o |-> req_ready_o) else $error("refuse ack");
   refuse_quiet_a: assert property (cmd_refused_o |=> write_strobe_n_o[*2])
      else $error("refused moved");
   busy_cmd_a: assert property ($rose(cmd_latch_o) && !ready_busy_n_i |->
      io_bus_o[7:0] == 8'hff || io_bus_o[7:0] == 8'h70) else $error("busy cmd");
   read_float_a: assert property (!read_strobe_n_o |-> io_bus_oe_n_o) else $error("read drive");
   protect_a: assert property (write_protect_req_i |=> !write_protect_n_o)
      else $error("protect");
endmodule
bind nfbi_ctrl nfbi_ctrl_monitor mon (
   .clk_i(clk_i),
   .arst_n_i(arst_n_i),
   .req_ready_o(req_ready_o),
   .cmd_refused_o(cmd_refused_o),
   .write_protect_req_i(write_protect_req_i),
   .chip_select_first_n_o(chip_select_first_n_o),
   .cmd_latch_o(cmd_latch_o),
   .addr_latch_o(addr_latch_o),
   .write_strobe_n_o(write_strobe_n_o),
   .read_strobe_n_o(read_strobe_n_o),
   .write_protect_n_o(write_protect_n_o),
   .io_bus_o(io_bus_o),
   .io_bus_oe_n_o(io_bus_oe_n_o),
   .ready_busy_n_i(ready_busy_n_i)
);

// [sim/nfbi_flash_model.sv]
// Behavioural sixteen-bit flash on the far side of the controller.
`timescale 1ns/1ps
// Busy time is kept off the clock grid so ready never changes on a sampling edge.
module nfbi_flash_model #(parameter int BUSY_NS = 4030, parameter bit POWER_ON_READ = 1'b1) (
   input wire logic ce_n_i,
   input wire logic cle_i,
   input wire logic ale_i,
   input wire logic we_n_i,
   input wire logic re_n_i,
   input wire logic wp_n_i,
   input wire logic [15:0] io_i,
   output logic [15:0] io_o,
   output logic io_oe_o,
   output logic rb_low_o
);
   logic [7:0] cmd_r;
   logic [7:0] addr_r [5];
   logic [2:0] acnt_r = 3'h0;
   logic [15:0] wdata_r;
   logic [10:0] col_r = 11'h000;
   logic busy_r = 1'b0;
   logic [15:0] dout_r = 16'h0000;
   // Power-on auto-read: busy for one array read, then the page streams from column zero.
   initial begin
      if (POWER_ON_READ) begin
         busy_r = 1'b1;
         busy_r <= #(BUSY_NS) 1'b0;
      end
   end
   // Busy runs on its own timer, so select going high cannot cut it short.
   always @(posedge we_n_i) begin
      if (!ce_n_i && cle_i) begin
         cmd_r = io_i[7:0];
         acnt_r = 3'h0;
         if (cmd_r == 8'h30 || (wp_n_i && (cmd_r == 8'h10 || cmd_r == 8'hd0))) begin
            col_r = {addr_r[1][2:0], addr_r[0]};
            busy_r = 1'b1;
            busy_r <= #(BUSY_NS) 1'b0;
         end
      end else if (!ce_n_i && ale_i && acnt_r < 3'h5) begin
         addr_r[acnt_r] = io_i[7:0];
         acnt_r = acnt_r + 3'h1;
      end else if (!ce_n_i && !ale_i) begin
         wdata_r = io_i;
      end
   end
   always @(negedge re_n_i) begin
      if (!ce_n_i) begin
         dout_r = 16'h5a00 ^ {5'h00, col_r};
         col_r = col_r + 11'h1;
      end
   end
   assign io_oe_o = !ce_n_i && !re_n_i;
   assign io_o = io_oe_o ? dout_r : ~dout_r;
   assign rb_low_o = busy_r;
endmodule

// [sim/nfbi_ctrl_bench.sv]
// Self-checking bench: controller against the behavioural flash.
`timescale 1ns/1ps
module nfbi_ctrl_bench;
   import nfbi_pkg::*;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic req_valid_i = 1'b0;
   nfbi_op_type op_i = NFBI_OP_CMD;
   logic [7:0] cmd_i = 8'h00;
   logic [28:0] addr_i = 29'h0;
   logic addr_row_only_i = 1'b0;
   logic [15:0] wdata_i = 16'h0000;
   logic write_protect_req_i = 1'b0;
   logic rdata_ready_i = 1'b1;
   logic req_ready_o, rdata_valid_o, flash_ready_o, cmd_refused_o, chip_select_first_n_o;
   logic cmd_latch_o, addr_latch_o, write_strobe_n_o, read_strobe_n_o, write_protect_n_o;
   logic io_bus_oe_n_o, ready_busy_n_i, fl_oe, fl_busy, refused;
   logic [15:0] rdata_o, io_bus_o, io_bus_i, fl_io;
   int errors = 0;
   int n_checks = 0;
   nfbi_ctrl dut (.*);
   nfbi_flash_model flash (.ce_n_i(chip_select_first_n_o), .cle_i(cmd_latch_o),
      .ale_i(addr_latch_o), .we_n_i(write_strobe_n_o), .re_n_i(read_strobe_n_o),
      .wp_n_i(write_protect_n_o), .io_i(io_bus_i), .io_o(fl_io), .io_oe_o(fl_oe),
      .rb_low_o(fl_busy));
   assign io_bus_i = io_bus_oe_n_o ? fl_io : io_bus_o;
   assign ready_busy_n_i = !fl_busy;
   always #50 clk_i = ~clk_i;
   task automatic wrap_up;
      $display("errors=%0d checks=%0d", errors, n_checks);
      if (errors == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [39:0] bytes5(input logic [28:0] a);
      return {6'h0, a[28:27], a[26:19], a[18:11], 5'h0, a[10:8], a[7:0]};
   endfunction
   // Waits out the whole pin phase so the flash has latched before we look.
   task automatic req(input nfbi_op_type op, input logic [7:0] c, input logic [28:0] a = 29'h0,
         input logic row = 1'b0, input logic [15:0] d = 16'h0000);
      int i;
      @(posedge clk_i);
      req_valid_i <= 1'b1;
      op_i <= op;
      cmd_i <= c;
      addr_i <= a;
      addr_row_only_i <= row;
      wdata_i <= d;
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (req_ready_o !== 1'b1 && i < 300);
      refused = cmd_refused_o;
      req_valid_i <= 1'b0;
      if (i >= 300) cmp(1, 0);
      // A five-byte address op is the longest phase, fifteen cycles after the accept.
      repeat (16) @(posedge clk_i);
   endtask
   task automatic wait_ready;
      int i;
      for (i = 0; i < 200 && flash_ready_o !== 1'b1; i++) @(posedge clk_i);
      cmp(flash_ready_o, 1'b1);
   endtask
   task automatic get(input logic [15:0] exp);
      int i;
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (rdata_valid_o !== 1'b1 && i < 100);
      if (rdata_valid_o !== 1'b1) cmp(1, 0);
      cmp(rdata_o, exp);
   endtask
   task automatic t_write(input logic [28:0] a);
      req(NFBI_OP_CMD, 8'h80);
      cmp(flash.cmd_r, 8'h80);
      req(NFBI_OP_ADDR, 8'h00, a);
      cmp({flash.addr_r[4], flash.addr_r[3], flash.addr_r[2], flash.addr_r[1],
         flash.addr_r[0]}, bytes5(a));
      req(NFBI_OP_WDATA, 8'h00, 29'h0, 1'b0, 16'hc3a5);
      cmp(flash.wdata_r, 16'hc3a5);
      req(NFBI_OP_CMD, 8'h10);
      cmp(flash_ready_o, write_protect_req_i);
   endtask
   task automatic t_erase(input logic [28:0] a);
      logic [39:0] b;
      b = bytes5(a);
      req(NFBI_OP_CMD, 8'h60);
      req(NFBI_OP_ADDR, 8'h00, a, 1'b1);
      cmp({flash.addr_r[2], flash.addr_r[1], flash.addr_r[0]}, b[39:16]);
      req(NFBI_OP_CMD, 8'hd0);
      req(NFBI_OP_CMD, 8'h60);
      cmp(refused, 1'b1);
      req(NFBI_OP_CMD, 8'h70);
      cmp(refused, 1'b0);
      wait_ready();
   endtask
   task automatic t_read(input logic [28:0] a);
      req(NFBI_OP_CMD, 8'h00);
      req(NFBI_OP_ADDR, 8'h00, a);
      req(NFBI_OP_CMD, 8'h30);
      wait_ready();
      rdata_ready_i <= 1'b0;
      req(NFBI_OP_RDATA, 8'h00);
      req(NFBI_OP_RDATA, 8'h00);
      cmp(rdata_valid_o, 1'b1);
      rdata_ready_i <= 1'b1;
      get(16'h5a00 ^ {5'h0, a[10:0]});
      get(16'h5a00 ^ {5'h0, a[10:0] + 11'h1});
      cmp(fl_oe, 1'b0);
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      cmp(flash_ready_o, 1'b0);
      wait_ready();
      rdata_ready_i <= 1'b0;
      req(NFBI_OP_RDATA, 8'h00);
      rdata_ready_i <= 1'b1;
      get(16'h5a00);
      t_write(29'h1234_5678);
      wait_ready();
      write_protect_req_i <= 1'b1;
      t_write(29'h0abc_def1);
      cmp(write_protect_n_o, 1'b0);
      write_protect_req_i <= 1'b0;
      t_erase(29'h1fff_ffff);
      t_read(29'h0000_07ff);
      wrap_up();
   end
   initial begin
      #3000000;
      cmp(1, 0);
      wrap_up();
   end
endmodule
